// File: rtl/gzsfc_top.sv
`timescale 1ns/1ps
`default_nettype none
module gzsfc_top #(
    parameter logic [11:0] THRESH_RESET = 12'h040
) (
    // Clock and power-up reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial link pins.
    input wire logic spi_sclk,
    input wire logic spi_si,
    input wire logic spi_cs_n,
    output logic spi_so,
    output logic spi_so_oe,
    // Reset pin and supply, thermal monitors.
    input wire logic ext_rst_n,
    input wire logic motor_supply_below_min,
    input wire logic motor_supply_uv,
    input wire logic motor_supply_ov,
    input wire logic overtemp,
    // Integrated back-EMF magnitude of the undriven coil.
    input wire logic [7:0] bemf_level,
    // Coil drive and monitor routing.
    output logic drive_en,
    output logic coil_a_on,
    output logic coil_b_on,
    output logic monitor_sel_b,
    output logic monitor_en,
    output logic sleep
);
    typedef struct packed {
        logic [12:0] pwr;
        logic [12:0] vel;
        logic [12:0] cpos;
        logic [12:0] zsc;
        logic [12:0] zcf;
        logic [11:0] thresh;
        gzsfc_pkg::gzsfc_zs_t zs;
        logic [9:0] tick;
        logic [11:0] integ;
        logic [11:0] acc;
        logic [11:0] pos;
        logic coil_b;
        logic alt;
        logic done;
        logic ot_shut;
        logic fl_ot;
        logic fl_ov;
        logic fl_clk;
        logic fl_uva;
        logic fl_uvb;
        logic [4:0] osc;
        logic [3:0] div_cnt;
        logic [3:0] cal_div;
        logic cal_arm;
        logic cal_run;
        logic [6:0] cal_cnt;
        logic cs_low_d;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } gzsfc_top_t;

    // Reset image: config zero except full-step time, threshold and calibration divider, undervoltage set.
    // Undervoltage flags set.
    localparam gzsfc_top_t RST_S = '{
        zcf: gzsfc_pkg::CF_RESET,
        thresh: THRESH_RESET,
        zs: gzsfc_pkg::ZS_IDLE,
        cal_div: gzsfc_pkg::CAL_DIV_RESET,
        fl_uva: 1'b1,
        fl_uvb: 1'b1,
        default: '0
    };
    localparam logic [4:0] OSC_LAST = 5'(gzsfc_pkg::OSC_DIV - 1);

    gzsfc_top_t s_ff, nxt_s;
    logic [15:0] sync_q;
    logic sclk_q, si_q, cs_n_q, rstpin_n_q, below_q;
    logic uv_q, ov_q, ot_q;
    logic [7:0] bemf_q;
    logic srst, word_stb, cs_low;
    logic [15:0] word, status;

    // Step spacing for the coming full step.
    function automatic logic [11:0] step_gap(input logic angle, input logic alt);
        if (!angle) begin
            step_gap = gzsfc_pkg::US_EVEN;
        end else begin
            step_gap = alt ? gzsfc_pkg::US_LONG : gzsfc_pkg::US_SHORT;
        end
    endfunction

    // All link, reset-pin, supply, thermal and back-EMF pins pass two flip-flops.
    gzsfc_sync #(
        .W(16)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({spi_sclk, spi_si, spi_cs_n, ext_rst_n, motor_supply_below_min,
            motor_supply_uv, motor_supply_ov, overtemp, bemf_level}),
        .q(sync_q)
    );
    assign {sclk_q, si_q, cs_n_q, rstpin_n_q, below_q, uv_q, ov_q, ot_q} = sync_q[15:8];
    assign bemf_q = sync_q[7:0];

    assign srst = !rstpin_n_q || below_q;

    gzsfc_spi u_spi (
        .hclk(hclk),
        .hresetn(hresetn),
        .srst(srst),
        .sclk(sclk_q),
        .si(si_q),
        .cs_n(cs_n_q),
        .so(spi_so),
        .so_oe(spi_so_oe),
        .status(status),
        .word(word),
        .word_stb(word_stb),
        .cs_low(cs_low)
    );

    // Status word sent first in every frame.
    always_comb begin
        status = '0;
        status[gzsfc_pkg::ST_OT] = s_ff.fl_ot;
        status[gzsfc_pkg::ST_OV] = s_ff.fl_ov;
        status[gzsfc_pkg::ST_CLK] = s_ff.fl_clk;
        status[gzsfc_pkg::ST_RUN] = s_ff.zs != gzsfc_pkg::ZS_IDLE;
        status[gzsfc_pkg::ST_DONE] = s_ff.done;
        status[gzsfc_pkg::ST_MOV] = s_ff.zs != gzsfc_pkg::ZS_IDLE;
        status[gzsfc_pkg::ST_UVB] = s_ff.fl_uvb;
        status[gzsfc_pkg::ST_UVA] = s_ff.fl_uva;
        status[5:0] = s_ff.acc[11:6];
    end

    // Next-state logic for the whole block.
    always_comb begin
        logic osc_t, us_t, busy, start, accept, cal_fail;
        logic [2:0] adr;
        logic [12:0] dat;
        logic [7:0] cal_sum;
        logic [9:0] blank_len, step_len;
        logic [11:0] total;
        nxt_s = s_ff;
        osc_t = s_ff.osc == OSC_LAST;
        us_t = osc_t && (s_ff.div_cnt + 4'h1 >= s_ff.cal_div);
        busy = s_ff.zs != gzsfc_pkg::ZS_IDLE;
        adr = word[15:13];
        dat = word[12:0];
        cal_fail = 1'b0;
        cal_sum = '0;
        start = 1'b0;
        accept = hsel && htrans[1] && hready && hsize == 3'h2;
        total = s_ff.integ + 12'(s_ff.zcf[10:gzsfc_pkg::CF_PRE_LSB]);
        blank_len = s_ff.zcf[gzsfc_pkg::CF_BLANK] ? gzsfc_pkg::BLANK_LONG
                                                  : gzsfc_pkg::BLANK_SHORT;
        step_len = {s_ff.zcf[12:11], s_ff.zcf[3:0], 4'h0};
        nxt_s.cs_low_d = cs_low;

        // Oscillator tick and calibrated microsecond tick.
        nxt_s.osc = osc_t ? 5'h00 : s_ff.osc + 5'h01;
        if (osc_t) begin
            nxt_s.div_cnt = us_t ? 4'h0 : s_ff.div_cnt + 4'h1;
        end

        if (word_stb) begin
            unique case (adr)
                gzsfc_pkg::ADR_PWR: begin
                    if (!busy) begin
                        nxt_s.pwr = dat;
                        nxt_s.cal_arm = dat[gzsfc_pkg::PE_CAL];
                        if (dat[gzsfc_pkg::PE_EN] && !ot_q) begin
                            nxt_s.ot_shut = 1'b0;
                        end
                    end
                end
                gzsfc_pkg::ADR_VEL: begin
                    if (!busy) begin
                        nxt_s.vel = dat;
                    end
                end
                gzsfc_pkg::ADR_POS: begin
                    if (!busy) begin
                        nxt_s.cpos = dat;
                    end
                end
                gzsfc_pkg::ADR_ZSC: begin
                    nxt_s.zsc = dat;
                    nxt_s.done = 1'b0;
                end
                gzsfc_pkg::ADR_ZCF: begin
                    if (!busy) begin
                        nxt_s.zcf = dat;
                    end
                end
                default: begin
                end
            endcase
            nxt_s.fl_ov = 1'b0;
            nxt_s.fl_clk = 1'b0;
            nxt_s.fl_uva = 1'b0;
            nxt_s.fl_uvb = 1'b0;
            nxt_s.fl_ot = nxt_s.ot_shut;
        end

        if (s_ff.cal_arm && cs_low) begin
            nxt_s.cal_run = 1'b1;
            if (osc_t && s_ff.cal_cnt != 7'h7f) begin
                nxt_s.cal_cnt = s_ff.cal_cnt + 7'h01;
            end
        end
        if (s_ff.cal_run && s_ff.cs_low_d && !cs_low) begin
            cal_sum = {1'b0, s_ff.cal_cnt} + (s_ff.pwr[gzsfc_pkg::PE_CENTER]
                ? gzsfc_pkg::CAL_OFS_CENTER : gzsfc_pkg::CAL_OFS_SLOW);
            cal_fail = cal_sum[7:4] < gzsfc_pkg::CAL_DIV_MIN;
            if (!cal_fail) begin
                nxt_s.cal_div = cal_sum[7:4];
            end
            nxt_s.cal_arm = 1'b0;
            nxt_s.cal_run = 1'b0;
            nxt_s.cal_cnt = '0;
        end

        if (ot_q) begin
            nxt_s.ot_shut = 1'b1;
            nxt_s.fl_ot = 1'b1;
        end
        if (ov_q) begin
            nxt_s.fl_ov = 1'b1;
        end
        if (uv_q) begin
            nxt_s.fl_uva = 1'b1;
            nxt_s.fl_uvb = 1'b1;
        end
        if (cal_fail) begin
            nxt_s.fl_clk = 1'b1;
        end

        // Zero-seek sequencer.
        start = nxt_s.zsc[gzsfc_pkg::ZS_EN] && s_ff.pwr[gzsfc_pkg::PE_EN]
                && !s_ff.ot_shut && !s_ff.done;
        unique case (s_ff.zs)
            gzsfc_pkg::ZS_IDLE: begin
                if (start) begin
                    nxt_s.zs = gzsfc_pkg::ZS_DECIDE;
                    nxt_s.integ = 12'hfff;
                end
            end
            gzsfc_pkg::ZS_BLANK: begin
                if (us_t) begin
                    nxt_s.tick = s_ff.tick + 10'h001;
                    if (s_ff.tick + 10'h001 >= blank_len) begin
                        nxt_s.zs = gzsfc_pkg::ZS_INTEG;
                    end
                end
            end
            gzsfc_pkg::ZS_INTEG: begin
                if (us_t) begin
                    nxt_s.tick = s_ff.tick + 10'h001;
                    nxt_s.integ = s_ff.integ + 12'(bemf_q);
                    if (s_ff.tick + 10'h001 >= step_len) begin
                        nxt_s.zs = gzsfc_pkg::ZS_DECIDE;
                    end
                end
            end
            gzsfc_pkg::ZS_DECIDE: begin
                if (s_ff.integ != 12'hfff) begin
                    nxt_s.acc = total;
                end
                if (s_ff.integ != 12'hfff && total <= s_ff.thresh
                        && !s_ff.zsc[gzsfc_pkg::ZS_SSD]) begin
                    nxt_s.zs = gzsfc_pkg::ZS_IDLE;
                    nxt_s.zsc[gzsfc_pkg::ZS_EN] = 1'b0;
                    nxt_s.done = 1'b1;
                    nxt_s.pos = '0;
                end else begin
                    nxt_s.zs = gzsfc_pkg::ZS_BLANK;
                    nxt_s.tick = '0;
                    nxt_s.integ = '0;
                    nxt_s.coil_b = !s_ff.coil_b;
                    nxt_s.alt = !s_ff.alt;
                    if (s_ff.pwr[gzsfc_pkg::PE_DIR]) begin
                        nxt_s.pos = s_ff.pos
                            + step_gap(s_ff.pwr[gzsfc_pkg::PE_ANGLE], s_ff.alt);
                    end else begin
                        nxt_s.pos = s_ff.pos
                            - step_gap(s_ff.pwr[gzsfc_pkg::PE_ANGLE], s_ff.alt);
                    end
                end
            end
        endcase
        if (busy && (!nxt_s.zsc[gzsfc_pkg::ZS_EN] || nxt_s.ot_shut)
                && !nxt_s.done) begin
            nxt_s.zs = gzsfc_pkg::ZS_IDLE;
        end

        // AHB-Lite: write data phase, then address phase with read data.
        if (s_ff.ap_wr && s_ff.ap_addr == gzsfc_pkg::A_THRESH) begin
            nxt_s.thresh = hwdata[11:0];
        end
        nxt_s.ap_wr = accept && hwrite;
        nxt_s.ap_addr = haddr[7:0];
        if (accept && !hwrite) begin
            unique case (haddr[7:0])
                gzsfc_pkg::A_STATUS: nxt_s.rdata = {16'h0000, status};
                gzsfc_pkg::A_THRESH: nxt_s.rdata = {20'h00000, nxt_s.thresh};
                gzsfc_pkg::A_POS: nxt_s.rdata = {4'h0, s_ff.acc, 4'h0, s_ff.pos};
                default: nxt_s.rdata = '0;
            endcase
        end

        if (srst) begin
            nxt_s = RST_S;
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= RST_S;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Bus answers: zero wait, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_ff.rdata;

    assign drive_en = s_ff.pwr[gzsfc_pkg::PE_EN] && !s_ff.ot_shut;
    assign coil_a_on = s_ff.zs != gzsfc_pkg::ZS_IDLE && !s_ff.coil_b;
    assign coil_b_on = s_ff.zs != gzsfc_pkg::ZS_IDLE && s_ff.coil_b;
    assign monitor_sel_b = !s_ff.coil_b;
    assign monitor_en = s_ff.zs != gzsfc_pkg::ZS_IDLE;
    assign sleep = !rstpin_n_q;
endmodule // gzsfc_top
`default_nettype wire

// File: rtl/gzsfc_pkg.sv
package gzsfc_pkg;
    // Clock rates and the divider to the 8 MHz internal oscillator tick.
    localparam int CLK_HZ = 200_000_000;
    localparam int OSC_HZ = 8_000_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    // Serial word length and register addresses in word bits 15:13.
    localparam int SPI_BITS = 16;
    localparam logic [2:0] ADR_PWR = 3'h0;
    localparam logic [2:0] ADR_VEL = 3'h1;
    localparam logic [2:0] ADR_POS = 3'h2;
    localparam logic [2:0] ADR_ZSC = 3'h4;
    localparam logic [2:0] ADR_ZCF = 3'h5;
    // Bit positions in the power/enable and zero-seek control registers.
    localparam int PE_EN = 0;
    localparam int PE_CAL = 3;
    localparam int PE_CENTER = 4;
    localparam int PE_ANGLE = 6;
    localparam int PE_DIR = 7;
    localparam int ZS_EN = 1;
    localparam int ZS_SSD = 4;
    // Zero-seek configuration fields.
    localparam int CF_BLANK = 4;
    localparam int CF_PRE_LSB = 5;
    localparam logic [12:0] CF_RESET = 13'h000f;
    localparam logic [9:0] BLANK_SHORT = 10'h004;
    localparam logic [9:0] BLANK_LONG = 10'h008;
    // Status word bit positions.
    localparam int ST_OT = 15;
    localparam int ST_OV = 14;
    localparam int ST_CLK = 13;
    localparam int ST_RUN = 12;
    localparam int ST_DONE = 11;
    localparam int ST_MOV = 10;
    localparam int ST_UVB = 8;
    localparam int ST_UVA = 6;
    // Calibration offsets and the legal divisor floor.
    localparam logic [7:0] CAL_OFS_SLOW = 8'h10;
    localparam logic [7:0] CAL_OFS_CENTER = 8'h08;
    localparam logic [3:0] CAL_DIV_MIN = 4'h4;
    localparam logic [3:0] CAL_DIV_RESET = 4'h8;
    // Microstep spacing between full steps.
    localparam logic [11:0] US_EVEN = 12'h006;
    localparam logic [11:0] US_SHORT = 12'h004;
    localparam logic [11:0] US_LONG = 12'h008;
    // AHB-Lite register byte offsets.
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_THRESH = 8'h04;
    localparam logic [7:0] A_POS = 8'h08;
    // Zero-seek sequencer states, Gray coded in listed order; DECIDE to BLANK flips both bits.
    typedef enum logic [1:0] {
        ZS_IDLE = 2'b00,
        ZS_BLANK = 2'b01,
        ZS_INTEG = 2'b11,
        ZS_DECIDE = 2'b10
    } gzsfc_zs_t;
endpackage

// File: rtl/gzsfc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gzsfc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gzsfc_sync_t;

    gzsfc_sync_t s_ff, nxt_s;

    // Two stages; only the second stage reads the first.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = d;
        nxt_s.s2 = s_ff.s1;
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.s2;
endmodule // gzsfc_sync
`default_nettype wire

// File: rtl/gzsfc_spi.sv
`timescale 1ns/1ps
`default_nettype none
module gzsfc_spi (
    // Clock and resets.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic srst,
    // Synchronised link pins.
    input wire logic sclk,
    input wire logic si,
    input wire logic cs_n,
    // Serial output pin.
    output logic so,
    output logic so_oe,
    // Status in, received word out.
    input wire logic [15:0] status,
    output logic [15:0] word,
    output logic word_stb,
    output logic cs_low
);
    typedef struct packed {
        logic sclk_d;
        logic cs_d;
        logic first;
        logic any;
        logic [3:0] cnt;
        logic [15:0] in_sr;
        logic [15:0] out_sr;
        logic [15:0] word;
        logic stb;
    } gzsfc_spi_t;

    gzsfc_spi_t s_ff, nxt_s;
    logic fall, rise, sel;

    // Shift engine: sample on falling, shift out on rising clock edges.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.sclk_d = sclk;
        nxt_s.cs_d = cs_n;
        nxt_s.stb = 1'b0;
        sel = !cs_n && !s_ff.cs_d;
        fall = sel && s_ff.sclk_d && !sclk;
        rise = sel && !s_ff.sclk_d && sclk;
        if (s_ff.cs_d && !cs_n) begin
            nxt_s.cnt = '0;
            nxt_s.any = 1'b0;
            nxt_s.first = 1'b1;
        end
        if (fall) begin
            nxt_s.in_sr = {s_ff.in_sr[14:0], si};
            nxt_s.cnt = s_ff.cnt + 4'h1;
            nxt_s.any = 1'b1;
        end
        if (rise) begin
            nxt_s.first = 1'b0;
            if (s_ff.first) begin
                nxt_s.out_sr = status;
            end else begin
                // The newest sampled bit reappears exactly one word later.
                nxt_s.out_sr = {s_ff.out_sr[14:0], s_ff.in_sr[0]};
            end
        end
        if (!s_ff.cs_d && cs_n && s_ff.any && s_ff.cnt == 4'h0) begin
            nxt_s.word = s_ff.in_sr;
            nxt_s.stb = 1'b1;
        end
        if (srst) begin
            nxt_s = '0;
            nxt_s.cs_d = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '{cs_d: 1'b1, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign so_oe = !s_ff.cs_d;
    assign so = s_ff.out_sr[15];
    assign word = s_ff.word;
    assign word_stb = s_ff.stb;
    assign cs_low = !s_ff.cs_d;
endmodule // gzsfc_spi
`default_nettype wire

// File: verif/gzsfc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gzsfc_monitor (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer.
    input wire logic hreadyout,
    input wire logic hresp,
    // Link and control pins.
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic ext_rst_n,
    input wire logic overtemp,
    // Drive outputs.
    input wire logic drive_en,
    input wire logic coil_a_on,
    input wire logic coil_b_on,
    input wire logic monitor_sel_b,
    input wire logic monitor_en,
    input wire logic sleep
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Relations between the watched ports.
    property p_resp; hreadyout && !hresp; endproperty
    a_resp: assert property (p_resp)
        else $error("bus answer not ready or not okay");
    property p_so_off; spi_cs_n [*4] |-> !spi_so_oe; endproperty
    a_so_off: assert property (p_so_off)
        else $error("serial output driven while deselected");
    property p_so_hold; (spi_so_oe && !spi_sclk) [*6] |-> $stable(spi_so); endproperty
    a_so_hold: assert property (p_so_hold)
        else $error("serial output moved while clock low");
    property p_sleep_on; !ext_rst_n [*4] |-> sleep; endproperty
    a_sleep_on: assert property (p_sleep_on)
        else $error("no sleep while reset pin low");
    property p_sleep_off; ext_rst_n [*4] |-> !sleep; endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("sleep while reset pin high");
    property p_rst_off; !ext_rst_n [*6] |-> !drive_en; endproperty
    a_rst_off: assert property (p_rst_off)
        else $error("driver on during reset");
    property p_ot_off; overtemp [*5] |-> !drive_en; endproperty
    a_ot_off: assert property (p_ot_off)
        else $error("driver on while overheated");
    property p_route; (monitor_en && $stable(coil_a_on)) [*2] |->
        monitor_sel_b == coil_a_on && coil_a_on != coil_b_on; endproperty
    a_route: assert property (p_route)
        else $error("monitor not on undriven coil");
    // Main scenarios reached.
    c_seek: cover property (monitor_en);
    c_frame: cover property (spi_so_oe && spi_sclk);
    c_sleep: cover property (sleep);
endmodule // gzsfc_monitor
bind gzsfc_top gzsfc_monitor gzsfc_monitor_inst (.hclk, .hresetn, .hreadyout, .hresp,
    .spi_sclk, .spi_cs_n, .spi_so, .spi_so_oe, .ext_rst_n, .overtemp, .drive_en,
    .coil_a_on, .coil_b_on, .monitor_sel_b, .monitor_en, .sleep);
`default_nettype wire

// File: verif/gzsfc_host.sv
`timescale 1ns/1ps
`default_nettype none
module gzsfc_host (
    // Link pins toward the device.
    output logic sclk,
    output logic si,
    output logic cs_n,
    // Serial answer from the device.
    input wire logic so,
    input wire logic so_oe
);
    // Idle: clock low, select high.
    initial begin
        sclk = 1'b0;
        si = 1'b1;
        cs_n = 1'b1;
    end
    // Opening off the bus clock grid, so no edge of both clocks meets.
    // Select falls, clock low.
    task automatic open_frame();
        #1.3;
        cs_n <= 1'b0;
        #100;
    endtask
    // A deselected answer reads as unknown and fails any compare.
    // MSB first word.
    // Data at rise, read before fall.
    task automatic word16(input logic [15:0] w, output logic [15:0] r);
        for (int i = 15; i >= 0; i--) begin
            si <= w[i];
            sclk <= 1'b1;
            #24;
            r[i] = so_oe ? so : 1'bx;
            sclk <= 1'b0;
            #24;
        end
    endtask
    // Released data line settles at its pull-down level.
    task automatic close_frame();
        #24;
        cs_n <= 1'b1;
        si <= 1'b0;
        #100;
    endtask
    // One whole single-word frame.
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        open_frame();
        word16(w, r);
        close_frame();
    endtask
endmodule // gzsfc_host
`default_nettype wire

// File: verif/tb_gzsfc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gzsfc_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic ext_rst_n = 1'b1, motor_supply_below_min = 1'b0, motor_supply_uv = 1'b0;
    logic motor_supply_ov = 1'b0, overtemp = 1'b0;
    logic [7:0] bemf_level = 8'h00;
    logic hreadyout, hresp, spi_sclk, spi_si, spi_cs_n, spi_so, spi_so_oe, sleep;
    logic drive_en, coil_a_on, coil_b_on, monitor_sel_b, monitor_en;
    int errors = 0, checked = 0;
    // Clock and the parts under test.
    always #2.5 hclk = ~hclk;
    gzsfc_top gzsfc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .spi_sclk, .spi_si,
        .spi_cs_n, .spi_so, .spi_so_oe, .ext_rst_n, .motor_supply_below_min,
        .motor_supply_uv, .motor_supply_ov, .overtemp, .bemf_level, .drive_en,
        .coil_a_on, .coil_b_on, .monitor_sel_b, .monitor_en, .sleep);
    gzsfc_host gzsfc_host_inst (.sclk(spi_sclk), .si(spi_si), .cs_n(spi_cs_n),
        .so(spi_so), .so_oe(spi_so_oe));
    // Compare, bus cycle and bounded waits.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_mon(input logic lvl);
        for (int n = 0; n < 20000 && monitor_en !== lvl; n++) @(posedge hclk);
    endtask
    task automatic wait_step();
        logic c;
        c = coil_a_on;
        for (int n = 0; n < 20000 && coil_a_on === c; n++) @(posedge hclk);
        chk("step taken", !c, coil_a_on);
    endtask
    // Reset image, read-write and unmapped places, then the link.
    task automatic t_regs();
        logic [31:0] d;
        logic [15:0] r, r2;
        ahb(1'b0, 32'h0, 32'h0, d);
        chk("status", 32'h140, d);
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("thresh", 32'h040, d);
        ahb(1'b1, 32'h4, 32'h123, d);
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("thresh back", 32'h123, d);
        ahb(1'b0, 32'hc, 32'h0, d);
        chk("unmapped", 32'h0, d);
        gzsfc_host_inst.frame(16'h6000, r);
        chk("first word", 32'h140, r);
        gzsfc_host_inst.open_frame();
        gzsfc_host_inst.word16(16'h6000, r);
        gzsfc_host_inst.word16(16'h6abc, r2);
        gzsfc_host_inst.close_frame();
        chk("flags cleared", 32'h0, r);
        chk("chained word", 32'h6000, r2);
        @(posedge hclk);
        motor_supply_ov <= 1'b1;
        repeat (10) @(posedge hclk);
        motor_supply_ov <= 1'b0;
        gzsfc_host_inst.frame(16'h6000, r);
        chk("overvoltage", 32'h4000, r);
        gzsfc_host_inst.frame(16'h6000, r);
        chk("ov cleared", 32'h0, r);
        gzsfc_host_inst.frame(16'h0008, r);
        gzsfc_host_inst.open_frame();
        gzsfc_host_inst.close_frame();
        gzsfc_host_inst.frame(16'h6000, r);
        chk("clock flag", 32'h2000, r);
        $display("test regs done");
    endtask
    // Seek that steps while moving, then stops on a stall.
    task automatic t_seek();
        logic [31:0] p1, p2;
        logic [15:0] r;
        gzsfc_host_inst.frame(16'h0001, r);
        chk("drive on", 32'h1, drive_en);
        gzsfc_host_inst.frame(16'ha001, r);
        gzsfc_host_inst.frame(16'h400c, r);
        ahb(1'b0, 32'h0, 32'h0, p1);
        chk("stationary", 32'h0, (p1 >> 10) & 32'h1);
        @(posedge hclk);
        bemf_level <= 8'hff;
        gzsfc_host_inst.frame(16'h8002, r);
        wait_mon(1'b1);
        chk("seeking", 32'h1, monitor_en);
        wait_step();
        ahb(1'b0, 32'h8, 32'h0, p1);
        wait_step();
        ahb(1'b0, 32'h8, 32'h0, p2);
        chk("step size", 32'hffa, (p2 - p1) & 32'hfff);
        chk("still seeking", 32'h1, monitor_en);
        bemf_level <= 8'h00;
        wait_mon(1'b0);
        chk("stopped", 32'h0, monitor_en);
        ahb(1'b0, 32'h8, 32'h0, p1);
        chk("zero pos", 32'h0, p1 & 32'hfff);
        ahb(1'b0, 32'h0, 32'h0, p1);
        chk("done", 32'h1, (p1 >> 11) & 32'h1);
        $display("test seek done");
    endtask
    // Endless seek with shutdown disabled, ignored write, abort.
    task automatic t_endless();
        logic [15:0] r;
        logic [31:0] p1, p2;
        gzsfc_host_inst.frame(16'h0041, r);
        gzsfc_host_inst.frame(16'h8000, r);
        gzsfc_host_inst.frame(16'h8012, r);
        wait_mon(1'b1);
        repeat (3) wait_step();
        chk("endless", 32'h1, monitor_en);
        ahb(1'b0, 32'h8, 32'h0, p1);
        repeat (2) wait_step();
        ahb(1'b0, 32'h8, 32'h0, p2);
        chk("step pair", 32'hff4, (p2 - p1) & 32'hfff);
        gzsfc_host_inst.frame(16'h0000, r);
        chk("write ignored", 32'h1, drive_en);
        gzsfc_host_inst.frame(16'h8000, r);
        chk("aborted", 32'h0, monitor_en);
        $display("test endless done");
    endtask
    // Overheat, then reset pin restores the default image.
    task automatic t_sleep();
        logic [31:0] d;
        overtemp <= 1'b1;
        repeat (10) @(posedge hclk);
        chk("hot off", 32'h0, drive_en);
        overtemp <= 1'b0;
        ext_rst_n <= 1'b0;
        repeat (10) @(posedge hclk);
        chk("sleep", 32'h1, sleep);
        ext_rst_n <= 1'b1;
        repeat (10) @(posedge hclk);
        ahb(1'b0, 32'h4, 32'h0, d);
        chk("thresh reset", 32'h040, d);
        ahb(1'b0, 32'h0, 32'h0, d);
        chk("status reset", 32'h140, d);
        $display("test sleep done");
    endtask
    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against a hang.
    initial begin
        #500000;
        errors++;
        summarize();
    end
    // Reset, then the tests in order.
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // The pin synchronisers hold the block in reset a few cycles longer.
        repeat (4) @(posedge hclk);
        t_regs();
        t_seek();
        t_endless();
        t_sleep();
        summarize();
    end
endmodule // tb_gzsfc_top
`default_nettype wire
